// ---- core/cei_irq.sv ----
// sticky interrupt status with write-one-to-clear and a mask
// assumes events are one-cycle pulses on i_clk
module cei_irq #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // events, software clear and mask
  input  wire logic [WIDTH-1:0] i_event,
  input  wire logic [WIDTH-1:0] i_clear,
  input  wire logic [WIDTH-1:0] i_mask,
  // status and interrupt line
  output logic      [WIDTH-1:0] o_status,
  output logic                  o_irq
);
  logic [WIDTH-1:0] next_status;
  logic             next_irq;

  if (WIDTH < 1) begin : g_chk
    $error("cei_irq needs WIDTH of at least one");
  end

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    next_status = (o_status & ~i_clear) | i_event;
    next_irq    = |(next_status & i_mask); // RULE_08
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_status <= '0;
      o_irq    <= 1'b0;
    end else begin
      o_status <= next_status;
      o_irq    <= next_irq;
    end
  end
endmodule

// ---- core/cei_pkg.sv ----
// constants shared by the comparator event and interrupt logic
// assumes one 20 MHz system clock and a byte-wide register port
package cei_pkg;
  // channel count, synchroniser depth and register port widths
  localparam int NUM_CH      = 3;
  localparam int SYNC_STAGES = 2;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 8;

  // register byte addresses: control and mode pair per channel, then interrupt enable and status
  localparam logic [7:0] ADDR_CTRL0  = 8'h00;
  localparam logic [7:0] ADDR_MODE0  = 8'h01;
  localparam logic [7:0] ADDR_CTRL1  = 8'h02;
  localparam logic [7:0] ADDR_MODE1  = 8'h03;
  localparam logic [7:0] ADDR_CTRL2  = 8'h04;
  localparam logic [7:0] ADDR_MODE2  = 8'h05;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h06;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h07;

  // control register fields
  localparam int CTRL_ON_BIT   = 7;
  localparam int CTRL_RES_BIT  = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYSP_LSB = 2;
  localparam int CTRL_HYSN_LSB = 0;

  // mode register fields
  localparam int MODE_RIE_BIT  = 5;
  localparam int MODE_FIE_BIT  = 4;
  localparam int MODE_RSTE_BIT = 2;
  localparam int MODE_RESP_LSB = 0;

  // values after reset
  localparam logic [7:0] CTRL_RESET_VAL  = 8'h00;
  localparam logic [7:0] MODE_RESET_VAL  = 8'h00;
  localparam logic [2:0] IRQEN_RESET_VAL = 3'h0;

  // port 2 analog inputs, positive pin of each channel; negative is next pin
  localparam int unsigned CMP_POS_PIN [NUM_CH] = '{6, 2, 4};
endpackage

// ---- core/cei_sync_edge.sv ----
// two-flop synchroniser and edge detector for comparator outputs
// assumes raw inputs are asynchronous to i_clk
module cei_sync_edge #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // asynchronous raw levels and channel enables
  input  wire logic [WIDTH-1:0] i_raw,
  input  wire logic [WIDTH-1:0] i_on,
  // synchronised level and one-cycle edge pulses
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] on_d;

  if (WIDTH < 1) begin : g_chk
    $error("cei_sync_edge needs WIDTH of at least one");
  end

  // meta feeds only sync; edges come from sync against prev
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
      on_d <= '0;
    end else begin
      meta <= i_raw;
      sync <= meta;
      prev <= sync;
      on_d <= i_on;
    end
  end

  // edges only while on for two cycles, so switching on or off is no edge
  always_comb begin
    o_level = sync;
    o_rise  = sync & ~prev & i_on & on_d;
    o_fall  = ~sync & prev & i_on & on_d;
  end
endmodule

// ---- core/cei_top.sv ----
// register file and control for three comparator channels
// assumes analog comparators outside; raw outputs arrive asynchronously
// register port: one-cycle strobes, read data valid the cycle after

// Summary of operation
// RULE_01 - three channels, each with own controls
// RULE_02 - response time and hysteresis per channel
// RULE_03 - on bit one runs, zero shuts down
// RULE_04 - pin output low while channel is off
// RULE_05 - output polled, interrupt, reset, pin
// RULE_06 - result bit readable at any time
// RULE_07 - rise and fall enables pick edges
// RULE_08 - interrupt also needs extended enable bit
// RULE_09 - falling edge sets fall flag; code sets it only while the fall enable is set
// RULE_10 - rising edge sets rise flag; code sets it only while the rise enable is set
// RULE_11 - software waits power-up before using output
// RULE_12 - inputs on port 2 pin pairs
// RULE_13 - synchronise output; flags cleared by writing zero
module cei_top #(
  parameter int NUM_CH = cei_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // raw comparator outputs from the analog side
  input  wire logic [2:0]  i_cmp_raw,
  // analog configuration
  output logic      [2:0]  o_cmp_on,
  output logic      [5:0]  o_resp_mode,
  output logic      [5:0]  o_hyst_pos,
  output logic      [5:0]  o_hyst_neg,
  output logic      [7:0]  o_p2_analog_mask,
  // digital uses of the result
  output logic      [2:0]  o_cmp_pin_out,
  output logic      [2:0]  o_cmp_reset_req,
  output logic             o_irq
);
  if (NUM_CH != 3) begin : g_chk
    $error("cei_top serves exactly three channels");
  end

  // each positive pin needs its negative partner above it inside port 2
  for (genvar g = 0; g < 3; g++) begin : g_pin_chk
    if (cei_pkg::CMP_POS_PIN[g] > 6) begin : g_bad
      $error("cei_top comparator pin pair outside port 2");
    end
  end

  // register state
  logic [2:0] on;
  logic [1:0] hysp   [3];
  logic [1:0] hysn   [3];
  logic [1:0] resp   [3];
  logic [2:0] rie;
  logic [2:0] fie;
  logic [2:0] rst_en;
  logic [2:0] rise_flag;
  logic [2:0] fall_flag;
  logic [2:0] irq_en;
  logic [7:0] rdata;

  logic [2:0] next_on;
  logic [1:0] next_hysp  [3];
  logic [1:0] next_hysn  [3];
  logic [1:0] next_resp  [3];
  logic [2:0] next_rie;
  logic [2:0] next_fie;
  logic [2:0] next_rst_en;
  logic [2:0] next_rise_flag;
  logic [2:0] next_fall_flag;
  logic [2:0] next_irq_en;
  logic [7:0] next_rdata;

  // next values of the output flops
  logic [5:0] next_resp_mode;
  logic [5:0] next_hyst_pos;
  logic [5:0] next_hyst_neg;
  logic [7:0] next_p2_mask;
  logic [2:0] next_pin_out;
  logic [2:0] next_reset_req;

  // synchroniser and interrupt wiring
  logic [2:0] level;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] result;
  logic [2:0] irq_event;
  logic [2:0] irq_clear;
  logic [2:0] irq_status;

  // one strobe decode, shared by every register
  function automatic logic hit(input logic strobe, input logic [7:0] a,
                               input logic [7:0] target);
    return strobe && (a == target);
  endfunction

  // packs one 2-bit field per channel, channel n at bits 2n+1:2n
  function automatic logic [5:0] pack2(input logic [1:0] f [3]);
    logic [5:0] p;
    p = '0;
    for (int ch = 0; ch < 3; ch++) begin
      p[2*ch +: 2] = f[ch];
    end
    return p;
  endfunction

  // control address of a channel, mode is the next byte
  function automatic logic [7:0] ctrl_addr(input int ch);
    logic [7:0] a;
    a = cei_pkg::ADDR_CTRL0;
    case (ch)
      1:       a = cei_pkg::ADDR_CTRL1;
      2:       a = cei_pkg::ADDR_CTRL2;
      default: a = cei_pkg::ADDR_CTRL0;
    endcase
    return a;
  endfunction

  function automatic logic [7:0] mode_addr(input int ch);
    logic [7:0] a;
    a = cei_pkg::ADDR_MODE0;
    case (ch)
      1:       a = cei_pkg::ADDR_MODE1;
      2:       a = cei_pkg::ADDR_MODE2;
      default: a = cei_pkg::ADDR_MODE0;
    endcase
    return a;
  endfunction

  // comparator outputs are asynchronous, so synchronise before edges
  cei_sync_edge #(
    .WIDTH (3)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_raw     (i_cmp_raw),
    .i_on      (on),
    .o_level   (level),
    .o_rise    (rise),
    .o_fall    (fall)
  ); // RULE_13

  // a channel that is off reads and drives as low
  assign result    = level & on; // RULE_06
  // only enabled edges reach the interrupt status
  assign irq_event = (rise & rie) | (fall & fie); // RULE_07
  assign irq_clear = hit(i_wr, i_addr, cei_pkg::ADDR_IRQ_ST) ? i_wdata[2:0] : 3'h0;

  cei_irq #(
    .WIDTH (3)
  ) u_irq (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_event   (irq_event),
    .i_clear   (irq_clear),
    .i_mask    (irq_en),
    .o_status  (irq_status),
    .o_irq     (o_irq)
  ); // RULE_08

  // register writes and flag updates
  always_comb begin
    next_on        = on;
    next_rie       = rie;
    next_fie       = fie;
    next_rst_en    = rst_en;
    next_irq_en    = irq_en;
    next_rise_flag = rise_flag;
    next_fall_flag = fall_flag;
    for (int ch = 0; ch < 3; ch++) begin // RULE_01
      next_hysp[ch] = hysp[ch];
      next_hysn[ch] = hysn[ch];
      next_resp[ch] = resp[ch];
      if (hit(i_wr, i_addr, ctrl_addr(ch))) begin
        next_on[ch]   = i_wdata[cei_pkg::CTRL_ON_BIT]; // RULE_03
        next_hysp[ch] = i_wdata[cei_pkg::CTRL_HYSP_LSB +: 2]; // RULE_02
        next_hysn[ch] = i_wdata[cei_pkg::CTRL_HYSN_LSB +: 2];
        // a zero written clears a flag; a one leaves it as it is
        if (!i_wdata[cei_pkg::CTRL_RISE_BIT]) begin
          next_rise_flag[ch] = 1'b0; // RULE_13
        end
        if (!i_wdata[cei_pkg::CTRL_FALL_BIT]) begin
          next_fall_flag[ch] = 1'b0;
        end
      end
      if (hit(i_wr, i_addr, mode_addr(ch))) begin
        next_rie[ch]    = i_wdata[cei_pkg::MODE_RIE_BIT]; // RULE_07
        next_fie[ch]    = i_wdata[cei_pkg::MODE_FIE_BIT];
        next_rst_en[ch] = i_wdata[cei_pkg::MODE_RSTE_BIT];
        next_resp[ch]   = i_wdata[cei_pkg::MODE_RESP_LSB +: 2]; // RULE_02
      end
      // hardware set wins over a clear in the same cycle
      if (fall[ch] && fie[ch]) begin
        next_fall_flag[ch] = 1'b1; // RULE_09
      end
      if (rise[ch] && rie[ch]) begin
        next_rise_flag[ch] = 1'b1; // RULE_10
      end
    end
    if (hit(i_wr, i_addr, cei_pkg::ADDR_IRQ_EN)) begin
      next_irq_en = i_wdata[2:0]; // RULE_08
    end
  end

  // read mux; unmapped addresses and idle cycles read zero
  always_comb begin
    next_rdata = 8'h00;
    if (i_rd) begin
      for (int ch = 0; ch < 3; ch++) begin
        if (i_addr == ctrl_addr(ch)) begin
          next_rdata[cei_pkg::CTRL_ON_BIT]          = on[ch];
          next_rdata[cei_pkg::CTRL_RES_BIT]         = result[ch]; // RULE_06
          next_rdata[cei_pkg::CTRL_RISE_BIT]        = rise_flag[ch];
          next_rdata[cei_pkg::CTRL_FALL_BIT]        = fall_flag[ch];
          next_rdata[cei_pkg::CTRL_HYSP_LSB +: 2]   = hysp[ch];
          next_rdata[cei_pkg::CTRL_HYSN_LSB +: 2]   = hysn[ch];
        end
        if (i_addr == mode_addr(ch)) begin
          next_rdata[cei_pkg::MODE_RIE_BIT]         = rie[ch];
          next_rdata[cei_pkg::MODE_FIE_BIT]         = fie[ch];
          next_rdata[cei_pkg::MODE_RSTE_BIT]        = rst_en[ch];
          next_rdata[cei_pkg::MODE_RESP_LSB +: 2]   = resp[ch];
        end
      end
      if (i_addr == cei_pkg::ADDR_IRQ_EN) begin
        next_rdata[2:0] = irq_en;
      end
      if (i_addr == cei_pkg::ADDR_IRQ_ST) begin
        next_rdata[2:0] = irq_status;
      end
    end
  end

  // outputs toward the analog side, the pins and the reset logic
  always_comb begin
    next_p2_mask   = 8'h00;
    next_resp_mode = pack2(next_resp); // RULE_02
    next_hyst_pos  = pack2(next_hysp);
    next_hyst_neg  = pack2(next_hysn);
    for (int ch = 0; ch < 3; ch++) begin
      // positive pin first, negative on the pin above it
      if (next_on[ch]) begin
        next_p2_mask[cei_pkg::CMP_POS_PIN[ch]]     = 1'b1; // RULE_12
        next_p2_mask[cei_pkg::CMP_POS_PIN[ch] + 1] = 1'b1;
      end
    end
    // both follow the new on bit, so a shutdown drops them in the same cycle
    next_pin_out   = level & next_on; // RULE_04
    // reset request while the result is low; software must wait power-up
    next_reset_req = rst_en & next_on & ~level; // RULE_05 RULE_11
  end

  // register everything; no logic in this process
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      on               <= {3{cei_pkg::CTRL_RESET_VAL[cei_pkg::CTRL_ON_BIT]}};
      rie              <= '0;
      fie              <= '0;
      rst_en           <= '0;
      rise_flag        <= '0;
      fall_flag        <= '0;
      irq_en           <= cei_pkg::IRQEN_RESET_VAL;
      rdata            <= 8'h00;
      o_resp_mode      <= '0;
      o_hyst_pos       <= '0;
      o_hyst_neg       <= '0;
      o_p2_analog_mask <= 8'h00;
      o_cmp_pin_out    <= '0;
      o_cmp_reset_req  <= '0;
      o_cmp_on         <= '0;
      // per-channel fields take the reset values of their registers
      for (int ch = 0; ch < 3; ch++) begin
        hysp[ch] <= cei_pkg::CTRL_RESET_VAL[cei_pkg::CTRL_HYSP_LSB +: 2];
        hysn[ch] <= cei_pkg::CTRL_RESET_VAL[cei_pkg::CTRL_HYSN_LSB +: 2];
        resp[ch] <= cei_pkg::MODE_RESET_VAL[cei_pkg::MODE_RESP_LSB +: 2];
      end
    end else begin
      on               <= next_on;
      rie              <= next_rie;
      fie              <= next_fie;
      rst_en           <= next_rst_en;
      rise_flag        <= next_rise_flag;
      fall_flag        <= next_fall_flag;
      irq_en           <= next_irq_en;
      rdata            <= next_rdata;
      o_resp_mode      <= next_resp_mode;
      o_hyst_pos       <= next_hyst_pos;
      o_hyst_neg       <= next_hyst_neg;
      o_p2_analog_mask <= next_p2_mask;
      o_cmp_pin_out    <= next_pin_out;
      o_cmp_reset_req  <= next_reset_req;
      o_cmp_on         <= next_on; // RULE_03
      for (int ch = 0; ch < 3; ch++) begin
        hysp[ch] <= next_hysp[ch];
        hysn[ch] <= next_hysn[ch];
        resp[ch] <= next_resp[ch];
      end
    end
  end

  // read data stands one cycle after the strobe
  assign o_rdata = rdata;
endmodule

// ---- tb/cei_checker.sv ----
// port assertions for the comparator event block
// bound into cei_top; one clock, synchronous reset
module cei_checker #(
  parameter int NUM_CH = 3
) (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // comparator side
  input wire logic [2:0] i_cmp_raw,
  input wire logic [2:0] o_cmp_on,
  input wire logic [5:0] o_resp_mode,
  input wire logic [5:0] o_hyst_pos,
  input wire logic [5:0] o_hyst_neg,
  input wire logic [7:0] o_p2_analog_mask,
  input wire logic [2:0] o_cmp_pin_out,
  input wire logic [2:0] o_cmp_reset_req,
  input wire logic       o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // all checks share the system clock and its reset
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_on_wr;
    i_wr && i_addr == cei_pkg::ADDR_CTRL0 |=> o_cmp_on[0] == $past(i_wdata[7]);
  endproperty
  a_on_wr: assert property (p_on_wr) else $error("on bit not applied");
  property p_indep;
    i_wr && i_addr == cei_pkg::ADDR_CTRL0 |=> $stable(o_cmp_on[2:1]);
  endproperty
  a_indep: assert property (p_indep) else $error("other channel disturbed");
  // pin and on bit are registered from the same next value
  property p_pin_off;
    (~o_cmp_on & o_cmp_pin_out) == 3'h0;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin high while off");
  property p_mask;
    o_p2_analog_mask == {{2{o_cmp_on[0]}}, {2{o_cmp_on[2]}}, {2{o_cmp_on[1]}}, 2'h0};
  endproperty
  a_mask: assert property (p_mask) else $error("analog pin mask wrong");
  property p_irq_off;
    i_wr && i_addr == cei_pkg::ADDR_IRQ_EN && i_wdata[2:0] == 3'h0
      ##1 !(i_wr && i_addr == cei_pkg::ADDR_IRQ_EN) |-> ##1 !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_mode;
    i_wr && i_addr == cei_pkg::ADDR_MODE1 |=> o_resp_mode[3:2] == $past(i_wdata[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("response mode not applied");
  // only a register write may take the level down
  property p_sticky;
    o_irq && !i_wr && !$past(i_wr) |=> o_irq;
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped uncleared");
  property p_rst_req;
    (o_cmp_reset_req & ~o_cmp_on) == 3'h0;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request while off");
endmodule

bind cei_top cei_checker #(.NUM_CH(NUM_CH)) i_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_raw(i_cmp_raw),
  .o_cmp_on(o_cmp_on), .o_resp_mode(o_resp_mode), .o_hyst_pos(o_hyst_pos),
  .o_hyst_neg(o_hyst_neg), .o_p2_analog_mask(o_p2_analog_mask),
  .o_cmp_pin_out(o_cmp_pin_out), .o_cmp_reset_req(o_cmp_reset_req), .o_irq(o_irq)
);

// ---- tb/cei_cmp_model.sv ----
// behavioural model of the three analog comparators on port 2
// outputs change just after i_clk edges; unreliable while off or settling
module cei_cmp_model #(
  parameter int PWRUP = 8
) (
  // clock
  input  wire logic       i_clk,
  // commanded levels, power enables, slow response select
  input  wire logic [2:0] i_level,
  input  wire logic [2:0] i_on,
  input  wire logic       i_slow,
  // raw outputs, bit n is channel n
  output logic      [2:0] o_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt [3];
  logic [2:0] dly [4];
  initial o_raw = 3'h0;
  // chatter rather than hold a stale level, so a design trusting it is caught
  always @(posedge i_clk) begin
    dly <= '{i_level, dly[0], dly[1], dly[2]};
    for (int n = 0; n < 3; n++) begin
      // an unknown enable before reset counts as off
      if (i_on[n] !== 1'b1 || cnt[n] != 0) begin
        o_raw[n] <= ~o_raw[n];
        cnt[n]   <= (i_on[n] === 1'b1) ? cnt[n] - 1 : PWRUP;
      end else begin
        o_raw[n] <= i_slow ? dly[3][n] : dly[0][n];
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the comparator event and interrupt block
// drives the register port and the comparator model from one 20 MHz clock
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         PWRUP    = 8;
  localparam logic [7:0] CTRL [3] = '{cei_pkg::ADDR_CTRL0, cei_pkg::ADDR_CTRL1,
                                      cei_pkg::ADDR_CTRL2};
  localparam logic [7:0] MODE [3] = '{cei_pkg::ADDR_MODE0, cei_pkg::ADDR_MODE1,
                                      cei_pkg::ADDR_MODE2};
  logic       i_clk, i_sys_rst, i_wr, i_rd, o_irq, slow;
  logic [7:0] i_addr, i_wdata, o_rdata, o_p2_analog_mask;
  logic [2:0] i_cmp_raw, level, o_cmp_on, o_cmp_pin_out, o_cmp_reset_req;
  logic [5:0] o_resp_mode, o_hyst_pos, o_hyst_neg;
  int         err_total = 0;
  int         checked   = 0;

  cei_top #(.NUM_CH(3)) i_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_raw(i_cmp_raw),
    .o_cmp_on(o_cmp_on), .o_resp_mode(o_resp_mode), .o_hyst_pos(o_hyst_pos),
    .o_hyst_neg(o_hyst_neg), .o_p2_analog_mask(o_p2_analog_mask),
    .o_cmp_pin_out(o_cmp_pin_out), .o_cmp_reset_req(o_cmp_reset_req), .o_irq(o_irq)
  );
  cei_cmp_model #(.PWRUP(PWRUP)) i_cmp (
    .i_clk(i_clk), .i_level(level), .i_on(o_cmp_on), .i_slow(slow), .o_raw(i_cmp_raw)
  );

  // 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // settle on the falling edge so sampled outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, exp);
  endtask
  task automatic do_reset;
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask

  // every mapped address and one unmapped read zero
  task automatic t_reset;
    for (int a = 0; a < 9; a++) begin
      rd(8'(a), 8'h00);
    end
    chk({5'h00, o_cmp_on}, 8'h00);
  endtask
  task automatic t_config;
    for (int c = 0; c < 3; c++) begin
      wr(CTRL[c], 8'h89);
      wr(MODE[c], 8'h06);
    end
    cyc(1);
    chk({5'h00, o_cmp_on}, 8'h07);
    chk(o_p2_analog_mask, 8'hfc);
    chk({2'h0, o_hyst_pos}, 8'h2a);
    chk({2'h0, o_hyst_neg}, 8'h15);
    chk({2'h0, o_resp_mode}, 8'h2a);
    cyc(PWRUP + 4);
    for (int c = 0; c < 3; c++) begin
      wr(CTRL[c], 8'h89);
    end
    wr(cei_pkg::ADDR_IRQ_ST, 8'h07);
  endtask
  // every edge enable setting on every channel, interrupt line disabled
  task automatic t_edges;
    logic [7:0] r;
    for (int c = 0; c < 3; c++) begin
      for (int m = 0; m < 4; m++) begin
        r = 8'h89 | (m[1] ? 8'h20 : 8'h00);
        wr(MODE[c], 8'(m * 16 + 6));
        @(posedge i_clk);
        level[c] <= 1'b1;
        cyc(8);
        chk({7'h00, o_cmp_pin_out[c]}, 8'h01);
        chk({7'h00, o_cmp_reset_req[c]}, 8'h00);
        rd(CTRL[c], r | 8'h40);
        @(posedge i_clk);
        level[c] <= 1'b0;
        cyc(8);
        chk({7'h00, o_cmp_reset_req[c]}, 8'h01);
        rd(CTRL[c], r | (m[0] ? 8'h10 : 8'h00));
        rd(cei_pkg::ADDR_IRQ_ST, (m != 0) ? 8'(1 << c) : 8'h00);
        chk({7'h00, o_irq}, 8'h00);
        wr(CTRL[c], 8'h89);
        wr(cei_pkg::ADDR_IRQ_ST, 8'h07);
        rd(CTRL[c], 8'h89);
      end
    end
  endtask
  // slow comparator; raise, mask, unmask and clear the interrupt
  task automatic t_irq;
    wr(MODE[1], 8'h26);
    @(posedge i_clk);
    level[1] <= 1'b1;
    slow     <= 1'b1;
    cyc(12);
    chk({7'h00, o_irq}, 8'h00);
    wr(cei_pkg::ADDR_IRQ_EN, 8'h02);
    cyc(2);
    chk({7'h00, o_irq}, 8'h01);
    cyc(20);
    chk({7'h00, o_irq}, 8'h01);
    wr(cei_pkg::ADDR_IRQ_EN, 8'h00);
    cyc(2);
    chk({7'h00, o_irq}, 8'h00);
    wr(cei_pkg::ADDR_IRQ_EN, 8'h02);
    wr(cei_pkg::ADDR_IRQ_ST, 8'h02);
    cyc(2);
    chk({7'h00, o_irq}, 8'h00);
  endtask
  // shut channel 0 down with its input high
  task automatic t_off;
    @(posedge i_clk);
    level <= 3'h7;
    cyc(8);
    wr(CTRL[0], 8'h09);
    cyc(2);
    chk({5'h00, o_cmp_on}, 8'h06);
    chk({5'h00, o_cmp_pin_out}, 8'h06);
    chk({5'h00, o_cmp_reset_req}, 8'h00);
    chk(o_p2_analog_mask, 8'h3c);
    rd(CTRL[0], 8'h09);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h00);
  endtask

  task automatic results;
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence, with a second reset in mid-run
  initial begin
    i_sys_rst = 1'b1;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    i_addr    = 8'h00;
    i_wdata   = 8'h00;
    level     = 3'h0;
    slow      = 1'b0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_config();
    t_edges();
    t_irq();
    t_off();
    do_reset();
    t_reset();
    results();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    results();
  end
endmodule
